// file: break_setup_pkg.sv
// Purpose: shared constants for the break-condition setup block
// Assumes: 32-bit register port, byte addresses on an 8-bit offset
// Notes:   qualifier field positions and codes used by decode and checks
package break_setup_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFF_CHAN_A_ADDR  = 8'h00;
	localparam logic [7:0] OFF_CHAN_A_MASK  = 8'h04;
	localparam logic [7:0] OFF_CHAN_A_QUAL  = 8'h08;
	localparam logic [7:0] OFF_CHAN_B_ADDR  = 8'h0c;
	localparam logic [7:0] OFF_CHAN_B_QUAL  = 8'h10;
	localparam logic [7:0] OFF_BREAK_STATUS = 8'h14;
	localparam logic [7:0] OFF_BREAK_MASK   = 8'h18;

	// ==========================================================
	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [7:0]  RST_QUAL = 8'h00;
	localparam logic [1:0]  RST_FLAG = 2'h0;

	// ==========================================================
	// channel A qualifier fields
	localparam int QUAL_W      = 8;
	localparam int MASTER_HI   = 7;
	localparam int MASTER_LO   = 6;
	localparam int FETCH_HI    = 5;
	localparam int FETCH_LO    = 4;
	localparam int DIR_HI      = 3;
	localparam int DIR_LO      = 2;
	localparam int SIZE_HI     = 1;
	localparam int SIZE_LO     = 0;

	// channel B qualifier bits
	localparam int XY_EN_BIT   = 1;
	localparam int XY_SEL_BIT  = 0;

	// status and mask bit positions
	localparam int HIT_A_BIT   = 0;
	localparam int HIT_B_BIT   = 1;

	// two-bit field codes
	localparam logic [1:0] FIELD_OFF  = 2'h0;
	localparam logic [1:0] MASTER_DMA = 2'h2;
	localparam logic [1:0] SIZE_BYTE  = 2'h1;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
	localparam logic [1:0] SIZE_LONG  = 2'h3;

	// x/y compare spans address bits 15 to 1
	localparam int XY_HI = 15;
	localparam int XY_LO = 1;
	localparam int XY_W  = 15;
	localparam int B_UPPER_LO = 17;

endpackage

// file: masked_compare.sv
// Purpose: masked equality of a watched value against a stored value
// Assumes: mask bit high removes that bit from the compare
// Notes:   purely combinational
`timescale 1ns/100ps
module masked_compare
#(
	parameter int W = 32
)
(
	input  wire logic [W-1:0] watched,
	input  wire logic [W-1:0] stored,
	input  wire logic [W-1:0] ignore,
	output      logic         hit
);

	// ==========================================================
	// compare
	assign hit = (((watched ^ stored) & ~ignore) == '0);

endmodule

// file: break_setup.sv
// Purpose: break-condition setup registers and channel compare logic
// Assumes: bus inputs are synchronous to clock; one monitored cycle per clock
// Notes:   only rst_n or a status write-one clears the registers, so contents survive standby
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
module break_setup
	import break_setup_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output      logic [31:0] reg_rdata,
	input  wire logic [31:0] cpu_address_bus,
	input  wire logic [31:0] cache_address_bus,
	input  wire logic        cyc_valid,
	input  wire logic        cyc_on_cache,
	input  wire logic        cyc_is_dma,
	input  wire logic        cyc_is_fetch,
	input  wire logic        cyc_is_write,
	input  wire logic [1:0]  cyc_size,
	input  wire logic [15:0] x_memory_address_bus,
	input  wire logic [15:0] y_memory_address_bus,
	input  wire logic        x_cyc_valid,
	input  wire logic        y_cyc_valid,
	output      logic        break_req_a,
	output      logic        break_req_b,
	output      logic        user_break_request,
	output      logic        irq
);

	// ==========================================================
	// register state
	logic [31:0] chan_a_break_address_r;
	logic [31:0] chan_a_address_mask_r;
	logic [7:0]  chan_a_cycle_qualifier_r;
	logic [31:0] chan_b_break_address_r;
	logic [1:0]  chan_b_cycle_qualifier_r;
	logic [1:0]  status_r;
	logic [1:0]  irq_mask_r;
	logic [31:0] rdata_nxt;
	logic        hit_a_r;
	logic        hit_b_r;

	// ==========================================================
	// decoded qualifier fields
	wire logic [1:0] chan_a_master_select       = chan_a_cycle_qualifier_r[MASTER_HI:MASTER_LO];
	wire logic [1:0] chan_a_fetch_access_select = chan_a_cycle_qualifier_r[FETCH_HI:FETCH_LO];
	wire logic [1:0] chan_a_direction_select    = chan_a_cycle_qualifier_r[DIR_HI:DIR_LO];
	wire logic [1:0] chan_a_size_select         = chan_a_cycle_qualifier_r[SIZE_HI:SIZE_LO];
	wire logic       xy_bus_enable              = chan_b_cycle_qualifier_r[XY_EN_BIT];
	wire logic       xy_bus_select              = chan_b_cycle_qualifier_r[XY_SEL_BIT];

	// ==========================================================
	// write strobes per register
	wire logic wr_a_addr   = reg_wr && (reg_addr == OFF_CHAN_A_ADDR);
	wire logic wr_a_mask   = reg_wr && (reg_addr == OFF_CHAN_A_MASK);
	wire logic wr_a_qual   = reg_wr && (reg_addr == OFF_CHAN_A_QUAL);
	wire logic wr_b_addr   = reg_wr && (reg_addr == OFF_CHAN_B_ADDR);
	wire logic wr_b_qual   = reg_wr && (reg_addr == OFF_CHAN_B_QUAL);
	wire logic wr_status   = reg_wr && (reg_addr == OFF_BREAK_STATUS);
	wire logic wr_irq_mask = reg_wr && (reg_addr == OFF_BREAK_MASK);

	// ==========================================================
	// channel A address and mask, cleared only by power-on reset
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chan_a_break_address_r <= RST_WORD;
			chan_a_address_mask_r  <= RST_WORD;
		end
		else
		begin
			if (wr_a_addr)
				chan_a_break_address_r <= reg_wdata;
			if (wr_a_mask)
				chan_a_address_mask_r <= reg_wdata;
		end
	end

	// channel A qualifier, upper three bytes not stored
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			chan_a_cycle_qualifier_r <= RST_QUAL;
		else if (wr_a_qual)
			chan_a_cycle_qualifier_r <= reg_wdata[QUAL_W-1:0];
	end

	// channel B address and bus choice
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chan_b_break_address_r   <= RST_WORD;
			chan_b_cycle_qualifier_r <= RST_FLAG;
		end
		else
		begin
			if (wr_b_addr)
				chan_b_break_address_r <= reg_wdata;
			if (wr_b_qual)
				chan_b_cycle_qualifier_r <= reg_wdata[1:0];
		end
	end

	// ==========================================================
	// channel A compare
	logic [31:0] watched_addr;
	logic        addr_hit_a;
	logic        master_ok;
	logic        fetch_ok;
	logic        dir_ok;
	logic        size_ok;
	logic        cond_a;

	assign watched_addr = cyc_on_cache ? cache_address_bus : cpu_address_bus;

	masked_compare #(.W(32)) u_cmp_a
	(
		.watched (watched_addr),
		.stored  (chan_a_break_address_r),
		.ignore  (chan_a_address_mask_r),
		.hit     (addr_hit_a)
	);

	// qualifier decode
	always_comb
	begin
		if (chan_a_master_select[0])
			master_ok = !cyc_is_dma;
		else if (chan_a_master_select == MASTER_DMA)
			master_ok = cyc_is_dma;
		else
			master_ok = 1'b1;
		unique case (chan_a_fetch_access_select)
			2'h1:    fetch_ok = cyc_is_fetch;
			2'h2:    fetch_ok = !cyc_is_fetch;
			default: fetch_ok = 1'b1;
		endcase
		unique case (chan_a_direction_select)
			2'h1:    dir_ok = !cyc_is_write;
			2'h2:    dir_ok = cyc_is_write;
			default: dir_ok = 1'b1;
		endcase
		if (chan_a_size_select == FIELD_OFF)
			size_ok = 1'b1;
		else
			size_ok = (cyc_size == chan_a_size_select);
	end

	assign cond_a = cyc_valid && addr_hit_a && master_ok && fetch_ok && dir_ok && size_ok;

	// ==========================================================
	// channel B compare
	logic        full_hit_b;
	logic        x_hit_b;
	logic        y_hit_b;
	logic        cond_b;

	masked_compare #(.W(32)) u_cmp_b
	(
		.watched (watched_addr),
		.stored  (chan_b_break_address_r),
		.ignore  (RST_WORD),
		.hit     (full_hit_b)
	);

	masked_compare #(.W(XY_W)) u_cmp_x
	(
		.watched (x_memory_address_bus[XY_HI:XY_LO]),
		.stored  (chan_b_break_address_r[31:B_UPPER_LO]),
		.ignore  ({XY_W{1'b0}}),
		.hit     (x_hit_b)
	);

	masked_compare #(.W(XY_W)) u_cmp_y
	(
		.watched (y_memory_address_bus[XY_HI:XY_LO]),
		.stored  (chan_b_break_address_r[XY_HI:XY_LO]),
		.ignore  ({XY_W{1'b0}}),
		.hit     (y_hit_b)
	);

	// with xy enabled only the selected x or y bus takes part; otherwise the full main-bus address is compared
	always_comb
	begin
		if (!xy_bus_enable)
			cond_b = cyc_valid && full_hit_b;
		else if (!xy_bus_select)
			cond_b = x_cyc_valid && x_hit_b;
		else
			cond_b = y_cyc_valid && y_hit_b;
	end

	// ==========================================================
	// break requests one cycle after the condition
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hit_a_r <= 1'b0;
			hit_b_r <= 1'b0;
		end
		else
		begin
			hit_a_r <= cond_a;
			hit_b_r <= cond_b;
		end
	end

	assign break_req_a        = hit_a_r;
	assign break_req_b        = hit_b_r;
	assign user_break_request = hit_a_r || hit_b_r;

	// ==========================================================
	// sticky status, write one to clear, set wins
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			status_r <= RST_FLAG;
		else
		begin
			status_r[HIT_A_BIT] <= hit_a_r ||
				(status_r[HIT_A_BIT] && !(wr_status && reg_wdata[HIT_A_BIT]));
			status_r[HIT_B_BIT] <= hit_b_r ||
				(status_r[HIT_B_BIT] && !(wr_status && reg_wdata[HIT_B_BIT]));
		end
	end

	// interrupt enables
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irq_mask_r <= RST_FLAG;
		else if (wr_irq_mask)
			irq_mask_r <= reg_wdata[1:0];
	end

	assign irq = |(status_r & irq_mask_r);

	// ==========================================================
	// read mux, data valid the cycle after the strobe
	always_comb
	begin
		rdata_nxt = RST_WORD;
		unique case (reg_addr)
			OFF_CHAN_A_ADDR:  rdata_nxt = chan_a_break_address_r;
			OFF_CHAN_A_MASK:  rdata_nxt = chan_a_address_mask_r;
			OFF_CHAN_A_QUAL:  rdata_nxt[QUAL_W-1:0] = chan_a_cycle_qualifier_r;
			OFF_CHAN_B_ADDR:  rdata_nxt = chan_b_break_address_r;
			OFF_CHAN_B_QUAL:  rdata_nxt[1:0] = chan_b_cycle_qualifier_r;
			OFF_BREAK_STATUS: rdata_nxt[1:0] = status_r;
			OFF_BREAK_MASK:   rdata_nxt[1:0] = irq_mask_r;
			default:          rdata_nxt = RST_WORD;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= RST_WORD;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= RST_WORD;
	end

	// ==========================================================
	// checks
	sequence s_write_a_addr;
		reg_wr && (reg_addr == OFF_CHAN_A_ADDR);
	endsequence
	sequence s_read_a_addr;
		reg_rd && (reg_addr == OFF_CHAN_A_ADDR);
	endsequence
	property p_a_addr_back;
		@(posedge clock) disable iff (!rst_n)
		s_write_a_addr ##1 s_read_a_addr |=> (reg_rdata == $past(reg_wdata, 2));
	endproperty
	a_a_addr_back: assert property (p_a_addr_back)
		else $error("channel A address did not read back");
	property p_mask_excludes;
		@(posedge clock) disable iff (!rst_n)
		(cyc_valid && (((watched_addr ^ chan_a_break_address_r) & ~chan_a_address_mask_r) != 0))
		|=> !break_req_a;
	endproperty
	a_mask_excludes: assert property (p_mask_excludes)
		else $error("break on an unmasked address difference");
	property p_qual_upper_zero;
		@(posedge clock) disable iff (!rst_n)
		reg_rd && (reg_addr == OFF_CHAN_A_QUAL) |=> (reg_rdata[31:QUAL_W] == 0);
	endproperty
	a_qual_upper_zero: assert property (p_qual_upper_zero)
		else $error("qualifier upper bits not zero");
	property p_master_cpu;
		@(posedge clock) disable iff (!rst_n)
		chan_a_master_select[0] && cyc_is_dma |=> !break_req_a;
	endproperty
	a_master_cpu: assert property (p_master_cpu)
		else $error("dma cycle broke on cpu select");
	property p_fetch_only;
		@(posedge clock) disable iff (!rst_n)
		(chan_a_fetch_access_select == 2'h1) && !cyc_is_fetch |=> !break_req_a;
	endproperty
	a_fetch_only: assert property (p_fetch_only)
		else $error("data cycle broke on fetch select");
	property p_read_only;
		@(posedge clock) disable iff (!rst_n)
		(chan_a_direction_select == 2'h1) && cyc_is_write |=> !break_req_a;
	endproperty
	a_read_only: assert property (p_read_only)
		else $error("write cycle broke on read select");
	property p_size_match;
		@(posedge clock) disable iff (!rst_n)
		(chan_a_size_select != FIELD_OFF) && (cyc_size != chan_a_size_select) |=> !break_req_a;
	endproperty
	a_size_match: assert property (p_size_match)
		else $error("size mismatch broke");
	property p_full_b;
		@(posedge clock) disable iff (!rst_n)
		!xy_bus_enable && cyc_valid && (watched_addr == chan_b_break_address_r) |=> break_req_b;
	endproperty
	a_full_b: assert property (p_full_b)
		else $error("channel B full address hit missed");
	property p_y_ignored;
		@(posedge clock) disable iff (!rst_n)
		xy_bus_enable && !xy_bus_select && !x_cyc_valid |=> !break_req_b;
	endproperty
	a_y_ignored: assert property (p_y_ignored)
		else $error("unselected bus caused a break");
	property p_break_follows;
		@(posedge clock) disable iff (!rst_n)
		cond_a |=> break_req_a ##1 (break_req_a == $past(cond_a));
	endproperty
	a_break_follows: assert property (p_break_follows)
		else $error("break request not one cycle after condition");
	property p_status_sticky;
		@(posedge clock) disable iff (!rst_n)
		break_req_a ##1 !(wr_status && reg_wdata[HIT_A_BIT]) |-> status_r[HIT_A_BIT];
	endproperty
	a_status_sticky: assert property (p_status_sticky)
		else $error("status bit lost");

endmodule

// file: core_bus_model.sv
// Purpose: processor-side model driving monitored bus cycles
// Assumes: called right after a rising edge; one cycle per clock
// Notes:   released buses show the inverse of the last value
`timescale 1ns/100ps
module core_bus_model
(
	input  wire logic        clock,
	output      logic [31:0] cpu_address_bus,
	output      logic [31:0] cache_address_bus,
	output      logic        cyc_valid,
	output      logic        cyc_on_cache,
	output      logic        cyc_is_dma,
	output      logic        cyc_is_fetch,
	output      logic        cyc_is_write,
	output      logic [1:0]  cyc_size,
	output      logic [15:0] x_memory_address_bus,
	output      logic [15:0] y_memory_address_bus,
	output      logic        x_cyc_valid,
	output      logic        y_cyc_valid
);
	// ==========================================================
	// idle buses at time zero
	initial
	begin
		{cpu_address_bus, cache_address_bus} = 64'h0;
		{cyc_valid, cyc_on_cache, cyc_is_dma, cyc_is_fetch, cyc_is_write, cyc_size} = 7'h0;
		{x_memory_address_bus, y_memory_address_bus, x_cyc_valid, y_cyc_valid} = 34'h0;
	end

	// ==========================================================
	// one cpu or cache cycle; the unused bus carries the inverse
	task automatic main_cycle(input logic [31:0] a, input logic [5:0] t);
		cpu_address_bus   <= t[5] ? ~a : a;
		cache_address_bus <= t[5] ? a : ~a;
		{cyc_on_cache, cyc_is_dma, cyc_is_fetch, cyc_is_write, cyc_size} <= t;
		cyc_valid <= 1'b1;
		@(posedge clock);
		cyc_valid         <= 1'b0;
		cpu_address_bus   <= ~cpu_address_bus;
		cache_address_bus <= ~cache_address_bus;
		cyc_size          <= ~cyc_size; // size scrambles once released; other attributes hold
	endtask

	// ==========================================================
	// one x and/or y memory cycle, v is {x valid, y valid}
	task automatic xy_cycle(input logic [15:0] x, input logic [15:0] y, input logic [1:0] v);
		x_memory_address_bus <= x;
		y_memory_address_bus <= y;
		{x_cyc_valid, y_cyc_valid} <= v;
		@(posedge clock);
		{x_cyc_valid, y_cyc_valid} <= 2'h0;
		x_memory_address_bus <= ~x;
		y_memory_address_bus <= ~y;
	endtask
endmodule

// file: break_setup_bench.sv
// Purpose: self-checking bench for the break-condition setup block
// Assumes: one register strobe at a time, with a gap cycle after each except a write that is read back at once
// Notes:   expectations come from shadow copies of written registers
`timescale 1ns/100ps
module break_setup_bench
	import break_setup_pkg::*;
;
	logic        clock;
	logic        rst_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [31:0] cpu_address_bus;
	logic [31:0] cache_address_bus;
	logic        cyc_valid, cyc_on_cache, cyc_is_dma, cyc_is_fetch, cyc_is_write;
	logic [1:0]  cyc_size;
	logic [15:0] x_memory_address_bus;
	logic [15:0] y_memory_address_bus;
	logic        x_cyc_valid, y_cyc_valid;
	logic        break_req_a, break_req_b, user_break_request, irq;
	logic [31:0] sh_a, sh_m, sh_b;
	logic [7:0]  sh_q;
	logic [1:0]  sh_bq;
	int          n_mismatch, check_count, cycles;

	break_setup u_dut
	(
		.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.cpu_address_bus, .cache_address_bus, .cyc_valid, .cyc_on_cache, .cyc_is_dma,
		.cyc_is_fetch, .cyc_is_write, .cyc_size, .x_memory_address_bus,
		.y_memory_address_bus, .x_cyc_valid, .y_cyc_valid, .break_req_a, .break_req_b,
		.user_break_request, .irq
	);

	core_bus_model u_bus
	(
		.clock, .cpu_address_bus, .cache_address_bus, .cyc_valid, .cyc_on_cache,
		.cyc_is_dma, .cyc_is_fetch, .cyc_is_write, .cyc_size, .x_memory_address_bus,
		.y_memory_address_bus, .x_cyc_valid, .y_cyc_valid
	);

	// ==========================================================
	// clock and cycle ceiling
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_mismatch++;
			$display("unexpected timeout: expected end, seen %0d cycles", cycles);
			tally_and_finish();
		end
	end

	// ==========================================================
	// comparison, verdict and expectation helpers
	task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", w, e, g);
		end
	endtask

	task automatic chk1(input string w, input logic e, input logic g);
		check(w, {31'h0, e}, {31'h0, g});
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// qualifier decode; t is {cache, dma, fetch, write, size}
	function automatic logic qual_ok(input logic [7:0] q, input logic [5:0] t);
		logic m, f, d, s;
		m = (q[7:6] == FIELD_OFF) || (q[6] ? !t[4] : t[4]);
		f = (q[5:4] == FIELD_OFF) || (q[5:4] == 2'h3) || (q[4] ? t[3] : !t[3]);
		d = (q[3:2] == FIELD_OFF) || (q[3:2] == 2'h3) || (q[2] ? !t[2] : t[2]);
		s = (q[1:0] == FIELD_OFF) || (q[1:0] == t[1:0]);
		return m && f && d && s;
	endfunction

	function automatic logic [5:0] rnd_t();
		return {4'($urandom_range(15, 0)), 2'($urandom_range(3, 1))};
	endfunction

	// ==========================================================
	// register bus: strobe one cycle, then a gap cycle after the task's last strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit rb = 1'b0);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= rb; // optional read of the same word with no gap
		case (a)
			OFF_CHAN_A_ADDR: sh_a = d;
			OFF_CHAN_A_MASK: sh_m = d;
			OFF_CHAN_A_QUAL: sh_q = d[7:0];
			OFF_CHAN_B_ADDR: sh_b = d;
			OFF_CHAN_B_QUAL: sh_bq = d[1:0];
			default: ;
		endcase
		@(posedge clock);
		if (rb)
		begin
			reg_rd <= 1'b0;
			#1;
			check("write then read", d, reg_rdata);
			@(posedge clock);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check(w, e, reg_rdata);
		@(posedge clock);
	endtask

	// ==========================================================
	// monitored cycles with break requests checked one cycle later
	task automatic main(input logic [31:0] ad, input logic [5:0] t);
		logic ea, eb;
		ea = (((ad ^ sh_a) & ~sh_m) == 32'h0) && qual_ok(sh_q, t);
		eb = !sh_bq[XY_EN_BIT] && (ad == sh_b);
		u_bus.main_cycle(ad, t);
		#1;
		chk1("break_req_a", ea, break_req_a);
		chk1("break_req_b", eb, break_req_b);
		chk1("user_break_request", ea | eb, user_break_request);
		@(posedge clock);
	endtask

	task automatic xy(input logic [15:0] x, input logic [15:0] y, input logic [1:0] v);
		logic eb;
		eb = sh_bq[XY_EN_BIT] && (sh_bq[XY_SEL_BIT] ? v[0] && y[15:1] == sh_b[15:1]
			: v[1] && x[15:1] == sh_b[31:17]);
		u_bus.xy_cycle(x, y, v);
		#1;
		chk1("break_req_b", eb, break_req_b);
		chk1("break_req_a", 1'b0, break_req_a);
		@(posedge clock);
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		int k;
		logic [31:0] v;
		{rst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = 43'h0;
		{sh_a, sh_m, sh_b, sh_q, sh_bq} = 106'h0;
		{n_mismatch, check_count, cycles} = '0;
		void'($urandom(90463));
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 8; i++)
			rd(8'(i * 4), 32'h0, "reset value");
		$display("test reset_values done");

		wr(OFF_CHAN_A_ADDR, $urandom(), 1'b1);
		wr(OFF_CHAN_A_MASK, $urandom());
		wr(OFF_CHAN_B_ADDR, $urandom());
		wr(OFF_CHAN_A_QUAL, 32'h0000_00ff);
		wr(8'h1c, 32'hffff_ffff);
		rd(OFF_CHAN_A_ADDR, sh_a, "chan_a_break_address");
		rd(OFF_CHAN_A_MASK, sh_m, "chan_a_address_mask");
		rd(OFF_CHAN_A_QUAL, 32'h0000_00ff, "chan_a_cycle_qualifier");
		rd(OFF_CHAN_B_ADDR, sh_b, "chan_b_break_address");
		rd(8'h1c, 32'h0, "unmapped");
		$display("test register_access done");

		wr(OFF_CHAN_A_QUAL, 32'h0);
		repeat (40)
		begin
			k = $urandom_range(31, 0);
			wr(OFF_CHAN_A_ADDR, $urandom());
			wr(OFF_CHAN_A_MASK, $urandom() & ~(32'h1 << k));
			v = sh_a ^ ($urandom() & sh_m);
			main(v, rnd_t());
			main(v ^ (32'h1 << k), rnd_t());
		end
		wr(OFF_CHAN_A_MASK, 32'hffff_ffff);
		main($urandom(), rnd_t());
		$display("test address_mask done");

		wr(OFF_CHAN_A_MASK, 32'h0);
		for (int q = 0; q < 256; q++)
		begin
			wr(OFF_CHAN_A_QUAL, 32'(q));
			repeat (3) main(sh_a, rnd_t());
		end
		$display("test qualifiers done");

		wr(OFF_CHAN_A_QUAL, 32'h0);
		repeat (8)
		begin
			wr(OFF_CHAN_B_ADDR, $urandom());
			for (int s = 0; s < 4; s++)
			begin
				wr(OFF_CHAN_B_QUAL, 32'(s));
				xy({sh_b[31:17], 1'($urandom())}, ~sh_b[15:0], 2'h2);
				xy(~sh_b[31:16], {sh_b[15:1], 1'($urandom())}, 2'h1);
				xy({sh_b[31:17], 1'b0}, ~sh_b[15:0], 2'h3);
				main(sh_b, rnd_t());
				main(sh_b ^ 32'h1, rnd_t());
			end
		end
		$display("test channel_b done");

		wr(OFF_CHAN_B_QUAL, 32'h0);
		wr(OFF_CHAN_B_ADDR, ~sh_a);
		wr(OFF_BREAK_STATUS, 32'h3);
		wr(OFF_BREAK_MASK, 32'h0);
		rd(OFF_BREAK_STATUS, 32'h0, "status");
		main(sh_a, rnd_t());
		main(sh_b, rnd_t());
		rd(OFF_BREAK_STATUS, 32'h3, "status");
		#1 chk1("irq", 1'b0, irq);
		@(posedge clock);
		for (int b = 1; b < 3; b++)
		begin
			wr(OFF_BREAK_MASK, 32'(b));
			#1 chk1("irq", 1'b1, irq);
			@(posedge clock);
			wr(OFF_BREAK_STATUS, 32'(b));
			#1 chk1("irq", 1'b0, irq);
			@(posedge clock);
		end
		rd(OFF_BREAK_STATUS, 32'h0, "status");
		$display("test interrupt done");

		wr(OFF_CHAN_A_MASK, 32'h5a5a_a5a5);
		wr(OFF_CHAN_A_QUAL, 32'h0000_005a);
		repeat (50) @(posedge clock);
		rd(OFF_CHAN_A_ADDR, sh_a, "held address");
		rd(OFF_CHAN_A_MASK, sh_m, "held mask");
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(OFF_CHAN_A_ADDR, 32'h0, "chan_a_break_address");
		rd(OFF_CHAN_A_MASK, 32'h0, "chan_a_address_mask");
		rd(OFF_CHAN_A_QUAL, 32'h0, "chan_a_cycle_qualifier");
		rd(OFF_CHAN_B_ADDR, 32'h0, "chan_b_break_address");
		$display("test hold_and_reset done");
		tally_and_finish();
	end
endmodule
